// ### rtl/acc_consts.vh
// timing counts, field positions and fixed codes for the converter control block
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// clock and time bases
`define ACC_CLK_PERIOD_PS 8000
`define ACC_PS_PER_NS 1000
`define ACC_PS_PER_US 1000000
`define ACC_CYCLES_PER_US (`ACC_PS_PER_US / `ACC_CLK_PERIOD_PS)

// least acquisition time rounds up, single conversion time rounds down
`define ACC_T_ACQ_NS 300
`define ACC_T_CONV_NS 600
`define ACC_T_ACQ_PS (`ACC_T_ACQ_NS * `ACC_PS_PER_NS)
`define ACC_ACQ_CYCLES ((`ACC_T_ACQ_PS + `ACC_CLK_PERIOD_PS - 1) / `ACC_CLK_PERIOD_PS)
`define ACC_CONV_CYCLES ((`ACC_T_CONV_NS * `ACC_PS_PER_NS) / `ACC_CLK_PERIOD_PS)

// offset calibration length, arbitrary
`define ACC_CAL_CYCLES 64

// serial frame: falling edge index that ends acquisition (ninth, counted from 0)
`define ACC_NINTH_FALL 4'h8

// target address decode
`define ACC_ADDR_BASE 7'h10

// result coding, straight binary
`define ACC_RESULT_ZERO 12'h000
`define ACC_RESULT_MID 12'h800
`define ACC_RESULT_FULL 12'hFFF

// averaging and pacing
`define ACC_AVG_FRAC_BITS 4
`define ACC_OSC1_SHIFT 5

// check code
`define ACC_CRC_POLY 8'h07
`define ACC_CRC_INIT 8'h00

// conversion sequencer states, one-hot
`define ACC_ST_IDLE 3'h1
`define ACC_ST_ACQ 3'h2
`define ACC_ST_CONV 3'h4

`endif

// ### rtl/acc_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module acc_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clocking
  input wire clk,
  input wire reset,
  input wire clk_en,
  // data
  input wire [W-1:0] async_in,
  output reg [W-1:0] level_out
);
  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;
  reg [W-1:0] stage3_reg;
  integer i;

  // stage1 feeds stage2 only; a bit moves once stages two and three agree
  always @(posedge clk) begin
    if (reset) begin
      stage1_reg <= INIT;
      stage2_reg <= INIT;
      stage3_reg <= INIT;
      level_out <= INIT;
    end else if (clk_en) begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_out[i] <= stage3_reg[i];
        end
      end
    end
  end
endmodule

// ### rtl/acc_ctrl.v
// channel, conversion pacing, calibration and address control of the converter
`timescale 1ns/1ps
`include "acc_consts.vh"
module acc_ctrl #(
  parameter CYCLES_PER_US = `ACC_CYCLES_PER_US,
  parameter CAL_CYCLES = `ACC_CAL_CYCLES
) (
  // clocking
  input wire clk,
  input wire reset,
  input wire clk_en,
  // channel configuration, latched on cfg_load
  input wire cfg_load,
  input wire [7:0] pin_cfg,
  input wire [7:0] gpio_dir,
  input wire [7:0] output_level_setting,
  input wire [7:0] output_driver_type,
  // shared channel pins
  input wire [7:0] shared_channel_pin_in,
  output reg [7:0] shared_channel_pin_out,
  output reg [7:0] shared_channel_pin_oe,
  output reg [7:0] pin_level_readback,
  // serial lines, observed only
  input wire scl_in,
  input wire sda_in,
  // conversion control
  input wire manual_conv_en,
  input wire host_conv_start,
  input wire auto_mode,
  input wire sequencing_run,
  input wire oscillator_choice,
  input wire [3:0] clk_div,
  input wire [2:0] avg_ratio,
  // analog core
  input wire [11:0] adc_code,
  output reg sample_switch_closed,
  output reg conv_start,
  output reg conv_busy,
  // results
  output reg [11:0] result_code,
  output reg result_valid,
  output reg [15:0] avg_result,
  output reg avg_done,
  // offset calibration
  input wire cal_set,
  output reg cal_bit,
  // target address
  input wire [2:0] addr_strap,
  input wire addr_prog_valid,
  input wire [6:0] addr_prog_value,
  output reg [6:0] target_address,
  // check code over transfer bytes
  input wire crc_clear,
  input wire crc_byte_valid,
  input wire [7:0] crc_byte,
  output reg [7:0] crc_value,
  // threshold events from the window comparator
  input wire [7:0] threshold_event,
  output reg alert_out
);
  // synchronised views of outside signals
  wire [1:0] bus_level;
  wire [7:0] chan_level;
  wire [2:0] strap_level;

  // I2C lines idle high; sampling at 8 ns still sees a high-speed bit
  acc_sync #(.W(2), .INIT(2'h3)) u_sync_bus (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in({scl_in, sda_in}),
    .level_out(bus_level)
  );

  acc_sync #(.W(8), .INIT(8'h00)) u_sync_chan (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(shared_channel_pin_in),
    .level_out(chan_level)
  );

  acc_sync #(.W(3), .INIT(3'h0)) u_sync_strap (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(addr_strap),
    .level_out(strap_level)
  );

  // channel configuration
  reg [7:0] pin_cfg_reg;
  reg [7:0] gpio_dir_reg;
  reg [7:0] out_level_reg;
  reg [7:0] drv_type_reg;

  always @(posedge clk) begin
    if (reset) begin
      pin_cfg_reg <= 8'h00;
      gpio_dir_reg <= 8'h00;
      out_level_reg <= 8'h00;
      drv_type_reg <= 8'h00;
    end else if (clk_en && cfg_load) begin
      pin_cfg_reg <= pin_cfg;
      gpio_dir_reg <= gpio_dir;
      out_level_reg <= output_level_setting;
      drv_type_reg <= output_driver_type;
    end
  end

  wire [7:0] is_output = pin_cfg_reg & gpio_dir_reg;
  wire [7:0] oe_next = is_output & (drv_type_reg | ~out_level_reg);
  wire [7:0] out_next = is_output & drv_type_reg & out_level_reg;

  always @(posedge clk) begin
    if (reset) begin
      shared_channel_pin_out <= 8'h00;
      shared_channel_pin_oe <= 8'h00;
      pin_level_readback <= 8'h00;
      alert_out <= 1'b0;
    end else if (clk_en) begin
      shared_channel_pin_out <= out_next;
      shared_channel_pin_oe <= oe_next;
      pin_level_readback <= chan_level;
      // comparator events only count on analog channels
      alert_out <= |(threshold_event & ~pin_cfg_reg);
    end
  end

  // serial frame watcher: start, stop, scl falling edges
  reg scl_prev_reg;
  reg sda_prev_reg;
  reg [3:0] fall_cnt_reg;
  wire scl_now = bus_level[1];
  wire sda_now = bus_level[0];
  wire frame_start = scl_now & scl_prev_reg & sda_prev_reg & ~sda_now;
  wire frame_stop = scl_now & scl_prev_reg & ~sda_prev_reg & sda_now;
  wire scl_fall = scl_prev_reg & ~scl_now;
  wire ninth_fall = scl_fall && (fall_cnt_reg == `ACC_NINTH_FALL);

  always @(posedge clk) begin
    if (reset) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      fall_cnt_reg <= 4'hF;
    end else if (clk_en) begin
      scl_prev_reg <= scl_now;
      sda_prev_reg <= sda_now;
      if (frame_start) begin
        fall_cnt_reg <= 4'h0;
      end else if (scl_fall && fall_cnt_reg != 4'hF) begin
        fall_cnt_reg <= fall_cnt_reg + 4'h1;
      end
    end
  end

  // pacing: cycle = 1us * (2 or 3) << (div/2) / 2, times 32 on the slow oscillator
  wire [9:0] half_us = clk_div[0] ? (10'h003 << clk_div[3:1]) : (10'h002 << clk_div[3:1]);
  wire [14:0] half_us_osc = oscillator_choice ? ({5'h00, half_us} << `ACC_OSC1_SHIFT) :
    {5'h00, half_us};
  wire [31:0] cycle_prod = half_us_osc * CYCLES_PER_US;
  wire [19:0] cycle_len = cycle_prod[20:1];
  reg [19:0] pace_cnt_reg;
  reg avg_active_reg;
  wire pace_run = (auto_mode && sequencing_run) || avg_active_reg;
  wire pace_tick = pace_run && (pace_cnt_reg >= cycle_len - 20'h1);

  always @(posedge clk) begin
    if (reset) begin
      pace_cnt_reg <= 20'h0;
    end else if (clk_en) begin
      if (!pace_run || pace_tick) begin
        pace_cnt_reg <= 20'h0;
      end else begin
        pace_cnt_reg <= pace_cnt_reg + 20'h1;
      end
    end
  end

  // conversion sequencer
  localparam [2:0] ST_IDLE = `ACC_ST_IDLE;
  localparam [2:0] ST_ACQ = `ACC_ST_ACQ;
  localparam [2:0] ST_CONV = `ACC_ST_CONV;
  localparam integer ACQ_LAST_N = `ACC_ACQ_CYCLES - 1;
  localparam integer CONV_LAST_N = `ACC_CONV_CYCLES - 1;
  localparam [6:0] ACQ_LAST = ACQ_LAST_N[6:0];
  localparam [6:0] CONV_LAST = CONV_LAST_N[6:0];

  reg [2:0] state_reg;
  reg internal_acq_reg;
  reg [6:0] phase_cnt_reg;
  reg [7:0] avg_left_reg;
  reg [18:0] avg_acc_reg;
  reg [7:0] cal_cnt_reg;
  wire manual_mode = manual_conv_en && !auto_mode;
  wire [18:0] avg_sum = avg_acc_reg + {7'h00, adc_code};
  wire [22:0] avg_scaled = {avg_sum, {`ACC_AVG_FRAC_BITS{1'b0}}} >> avg_ratio;
  wire conv_end = (state_reg == ST_CONV) && (phase_cnt_reg == CONV_LAST);
  wire internal_go = pace_tick && !cal_bit;

  always @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      internal_acq_reg <= 1'b0;
      phase_cnt_reg <= 7'h00;
      sample_switch_closed <= 1'b0;
      conv_start <= 1'b0;
      conv_busy <= 1'b0;
    end else if (clk_en) begin
      conv_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          phase_cnt_reg <= 7'h00;
          if (internal_go) begin
            state_reg <= ST_ACQ;
            internal_acq_reg <= 1'b1;
            sample_switch_closed <= 1'b1;
          end else if (manual_mode && frame_start && !cal_bit && !avg_active_reg) begin
            state_reg <= ST_ACQ;
            internal_acq_reg <= 1'b0;
            sample_switch_closed <= 1'b1;
          end
        end
        ST_ACQ: begin
          if (internal_acq_reg) begin
            phase_cnt_reg <= phase_cnt_reg + 7'h01;
            if (phase_cnt_reg == ACQ_LAST) begin
              state_reg <= ST_CONV;
              phase_cnt_reg <= 7'h00;
              sample_switch_closed <= 1'b0;
              conv_start <= 1'b1;
              conv_busy <= 1'b1;
            end
          end else if (ninth_fall) begin
            state_reg <= ST_CONV;
            sample_switch_closed <= 1'b0;
            conv_start <= 1'b1;
            conv_busy <= 1'b1;
          end else if (frame_stop) begin
            state_reg <= ST_IDLE;
            sample_switch_closed <= 1'b0;
          end
        end
        ST_CONV: begin
          // fixed length whatever the pacing settings
          phase_cnt_reg <= phase_cnt_reg + 7'h01;
          if (conv_end) begin
            state_reg <= ST_IDLE;
            phase_cnt_reg <= 7'h00;
            conv_busy <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sample_switch_closed <= 1'b0;
          conv_busy <= 1'b0;
        end
      endcase
    end
  end

  // results and averaging
  always @(posedge clk) begin
    if (reset) begin
      result_code <= `ACC_RESULT_ZERO;
      result_valid <= 1'b0;
      avg_result <= 16'h0000;
      avg_done <= 1'b0;
      avg_active_reg <= 1'b0;
      avg_left_reg <= 8'h00;
      avg_acc_reg <= 19'h0;
    end else if (clk_en) begin
      result_valid <= 1'b0;
      avg_done <= 1'b0;
      if (host_conv_start && avg_ratio != 3'h0 && !avg_active_reg && !cal_bit) begin
        // one host start launches the whole averaging run
        avg_active_reg <= 1'b1;
        avg_left_reg <= 8'h01 << avg_ratio;
        avg_acc_reg <= 19'h0;
      end
      if (conv_end) begin
        result_code <= adc_code;
        result_valid <= 1'b1;
        if (avg_active_reg) begin
          avg_acc_reg <= avg_sum;
          avg_left_reg <= avg_left_reg - 8'h01;
          if (avg_left_reg == 8'h01) begin
            avg_active_reg <= 1'b0;
            avg_result <= avg_scaled[15:0];
            avg_done <= 1'b1;
          end
        end
      end
    end
  end

  // offset calibration; a new set in the finishing cycle keeps the bit
  wire cal_finish = cal_bit && (cal_cnt_reg == CAL_CYCLES[7:0] - 8'h01);

  always @(posedge clk) begin
    if (reset) begin
      cal_bit <= 1'b0;
      cal_cnt_reg <= 8'h00;
    end else if (clk_en) begin
      // sequencing is not checked; the host must have stopped it first
      if (cal_set) begin
        cal_bit <= 1'b1;
        cal_cnt_reg <= 8'h00;
      end else if (cal_finish) begin
        cal_bit <= 1'b0;
        cal_cnt_reg <= 8'h00;
      end else if (cal_bit) begin
        cal_cnt_reg <= cal_cnt_reg + 8'h01;
      end
    end
  end

  // target address: the synchroniser shows the strap only after four edges, load on the fifth
  reg [2:0] strap_wait_reg;

  always @(posedge clk) begin
    if (reset) begin
      strap_wait_reg <= 3'h0;
      target_address <= `ACC_ADDR_BASE;
    end else if (clk_en) begin
      if (strap_wait_reg != 3'h5) begin
        strap_wait_reg <= strap_wait_reg + 3'h1;
        if (strap_wait_reg == 3'h4) begin
          target_address <= `ACC_ADDR_BASE + {4'h0, strap_level};
        end
      end else if (addr_prog_valid) begin
        target_address <= addr_prog_value;
      end
    end
  end

  // check code, msb first
  function [7:0] crc_step;
    input [7:0] crc_in;
    input [7:0] data;
    integer k;
    reg [7:0] c;
    begin
      c = crc_in ^ data;
      for (k = 0; k < 8; k = k + 1) begin
        c = c[7] ? ({c[6:0], 1'b0} ^ `ACC_CRC_POLY) : {c[6:0], 1'b0};
      end
      crc_step = c;
    end
  endfunction

  always @(posedge clk) begin
    if (reset) begin
      crc_value <= `ACC_CRC_INIT;
    end else if (clk_en) begin
      if (crc_clear) begin
        crc_value <= `ACC_CRC_INIT;
      end else if (crc_byte_valid) begin
        crc_value <= crc_step(crc_value, crc_byte);
      end
    end
  end
endmodule

// ### dv/acc_ctrl_sva.sv
// assertions on the converter control ports
`timescale 1ns/1ps
module acc_ctrl_sva #(
  parameter int CYCLES_PER_US = 125,
  parameter int CAL_CYCLES = 4
) (
  // clocking
  input wire clk,
  input wire reset,
  // calibration and address
  input wire cal_set,
  input wire cal_bit,
  input wire addr_prog_valid,
  input wire [6:0] addr_prog_value,
  input wire [6:0] target_address,
  // conversion
  input wire sample_switch_closed,
  input wire conv_start,
  input wire conv_busy,
  input wire result_valid,
  // check code and pins
  input wire crc_clear,
  input wire [7:0] crc_value,
  input wire [7:0] shared_channel_pin_out,
  input wire [7:0] shared_channel_pin_oe
);
  // one cycle of slack, the exact clear edge is a design choice
  localparam int CAL_HI = CAL_CYCLES + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_all_analog: assert property (
    disable iff (1'b0) reset |=> shared_channel_pin_oe == 8'h00)
    else $error("channel driven after reset");
  a_cal_set_starts: assert property (cal_set |=> cal_bit)
    else $error("calibration did not start");
  a_cal_self_clear: assert property ($rose(cal_bit) |-> ##[1:CAL_HI] !cal_bit)
    else $error("calibration bit stuck");
  a_switch_opens: assert property (
    $fell(sample_switch_closed) |-> conv_start && conv_busy)
    else $error("switch opened without start");
  a_conv_fixed_len: assert property ($rose(conv_busy) |-> ##75 !conv_busy && result_valid)
    else $error("conversion length wrong");
  a_addr_prog: assert property (
    addr_prog_valid |=> target_address == $past(addr_prog_value))
    else $error("address not programmed");
  a_crc_clear: assert property (crc_clear |=> crc_value == 8'h00)
    else $error("check code not cleared");
  a_drive_type: assert property (
    (shared_channel_pin_out & ~shared_channel_pin_oe) == 8'h00)
    else $error("pin high without enable");
endmodule
bind acc_ctrl acc_ctrl_sva #(.CYCLES_PER_US(CYCLES_PER_US), .CAL_CYCLES(CAL_CYCLES))
  acc_ctrl_sva_i (
  .clk, .reset, .cal_set, .cal_bit, .addr_prog_valid, .addr_prog_value, .target_address,
  .sample_switch_closed, .conv_start, .conv_busy, .result_valid, .crc_clear, .crc_value,
  .shared_channel_pin_out, .shared_channel_pin_oe);

// ### dv/acc_host_model.sv
// host side model driving the serial clock and data lines
`timescale 1ns/1ps
module acc_host_model (
  // serial lines, pulled up when idle
  output logic scl,
  output logic sda
);
  int falls;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    falls = 0;
  end
  // clock stands high between frames; ninth bit released, reads as nack
  task frame(input logic [7:0] d);
    falls = 0;
    sda = 1'b0;
    #80;
    for (int i = 0; i < 10; i++) begin
      scl = 1'b0;
      falls++;
      #40 sda = (i < 8) ? d[7 - i] : (i == 8);
      #40 scl = 1'b1;
      #80;
    end
    sda = 1'b1;
  endtask
endmodule

// ### dv/acc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module acc_ctrl_tb;
  localparam int CPU = 2;
  localparam int CAL = 4;
  logic clk, reset, clk_en, cfg_load, manual_conv_en, host_conv_start, auto_mode, manual;
  logic sequencing_run, oscillator_choice, cal_set, addr_prog_valid, crc_clear, crc_byte_valid;
  logic [7:0] pin_cfg, gpio_dir, output_level_setting, output_driver_type, shared_channel_pin_in;
  logic [7:0] crc_byte, threshold_event, e;
  logic [3:0] clk_div;
  logic [2:0] avg_ratio, addr_strap;
  logic [11:0] adc_code;
  logic [6:0] addr_prog_value;
  wire scl_in, sda_in, sample_switch_closed, conv_start, conv_busy, result_valid, avg_done;
  wire cal_bit, alert_out;
  wire [7:0] shared_channel_pin_out, shared_channel_pin_oe, pin_level_readback, crc_value;
  wire [11:0] result_code;
  wire [15:0] avg_result;
  wire [6:0] target_address;
  wire [7:0] exp_oe = pin_cfg & gpio_dir & (output_driver_type | ~output_level_setting);
  wire [7:0] exp_out = pin_cfg & gpio_dir & output_driver_type & output_level_setting;
  int num_errors, samples_checked, n, starts, cycles;
  int seed = 32'h0198;
  logic [11:0] codes [4];
  logic [4:0] tbl [4] = '{5'h0D, 5'h0F, 5'h13, 5'h14};
  acc_ctrl #(.CYCLES_PER_US(CPU), .CAL_CYCLES(CAL)) acc_ctrl_i (.clk, .reset, .clk_en, .cfg_load,
    .pin_cfg, .gpio_dir, .output_level_setting, .output_driver_type, .shared_channel_pin_in,
    .shared_channel_pin_out, .shared_channel_pin_oe, .pin_level_readback, .scl_in, .sda_in,
    .manual_conv_en, .host_conv_start, .auto_mode, .sequencing_run, .oscillator_choice, .clk_div,
    .avg_ratio, .adc_code, .sample_switch_closed, .conv_start, .conv_busy, .result_code,
    .result_valid, .avg_result, .avg_done, .cal_set, .cal_bit, .addr_strap, .addr_prog_valid,
    .addr_prog_value, .target_address, .crc_clear, .crc_byte_valid, .crc_byte, .crc_value,
    .threshold_event, .alert_out);
  acc_host_model acc_host_model_i (.scl(scl_in), .sda(sda_in));
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task load();
    cfg_load = 1'b1;
    tick(1);
    cfg_load = 1'b0;
  endtask
  // 0 start, 1 result, 2 average; a hang counts as a mismatch
  task wait_on(input int w);
    n = 0;
    while (!(w == 0 ? conv_start : w == 1 ? result_valid : avg_done) && n < 5000) begin
      tick(1);
      n++;
    end
    if (n >= 5000) num_errors++;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  function automatic int pace(input logic [4:0] v);
    return ((v[0] ? 3 : 2) << v[3:1]) * (v[4] ? 32 : 1) * CPU / 2;
  endfunction
  task conclude();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  always @(negedge clk) begin
    if (conv_start === 1'b1) starts++;
    if (manual && conv_start === 1'b1) chk("falls", 16'(acc_host_model_i.falls), 16'h0009);
  end
  initial begin
    {reset, cfg_load, host_conv_start, auto_mode, sequencing_run, oscillator_choice} = 6'h20;
    {cal_set, addr_prog_valid, crc_clear, crc_byte_valid, manual} = 5'h00;
    {pin_cfg, gpio_dir, output_level_setting, output_driver_type} = 32'h00000000;
    {shared_channel_pin_in, crc_byte, threshold_event} = 24'h000000;
    {clk_div, avg_ratio, addr_strap, adc_code, addr_prog_value} = 29'h00000000;
    clk_en = 1'b1;
    manual_conv_en = 1'b1;
    codes = '{12'h000, 12'h800, 12'hFFF, 12'($random(seed))};
    tick(2);
    reset = 1'b0;
    tick(6);
    chk("oe after reset", shared_channel_pin_oe, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      addr_strap = 3'(s);
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      tick(6);
      chk("address", target_address, 16'(16 + s));
    end
    addr_prog_value = 7'($random(seed));
    addr_prog_valid = 1'b1;
    tick(1);
    addr_prog_valid = 1'b0;
    addr_strap = 3'h2;
    tick(6);
    chk("programmed address", target_address, addr_prog_value);
    $display("address test done");
    repeat (8) begin
      {pin_cfg, gpio_dir, output_level_setting, output_driver_type} = $random(seed);
      shared_channel_pin_in = 8'($random(seed));
      load();
      tick(5);
      chk("oe", shared_channel_pin_oe, exp_oe);
      chk("out", shared_channel_pin_out, exp_out);
      chk("level", pin_level_readback, shared_channel_pin_in);
    end
    pin_cfg = 8'h00;
    load();
    threshold_event = 8'h10;
    tick(5);
    chk("oe analog", shared_channel_pin_oe, 16'h0000);
    chk("alert", alert_out, 16'h0001);
    threshold_event = 8'h00;
    tick(5);
    chk("alert idle", alert_out, 16'h0000);
    $display("pin test done");
    crc_clear = 1'b1;
    tick(1);
    crc_clear = 1'b0;
    crc_byte_valid = 1'b1;
    e = 8'h00;
    repeat (3) begin
      crc_byte = 8'($random(seed));
      e = crc8(e, crc_byte);
      tick(1);
    end
    crc_byte_valid = 1'b0;
    tick(1);
    chk("crc", crc_value, e);
    sequencing_run = 1'b0;
    cal_set = 1'b1;
    tick(1);
    cal_set = 1'b0;
    n = 0;
    while (cal_bit === 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk("cal length", 16'(n), 16'(CAL));
    $display("crc and calibration done");
    manual = 1'b1;
    foreach (codes[i]) begin
      adc_code = codes[i];
      fork
        acc_host_model_i.frame(8'($random(seed)));
        wait_on(0);
      join
      wait_on(1);
      chk("result", result_code, codes[i]);
      tick(1);
    end
    manual = 1'b0;
    $display("manual test done");
    auto_mode = 1'b1;
    sequencing_run = 1'b1;
    // first interval may straddle the old setting, so time the second
    foreach (tbl[i]) begin
      {oscillator_choice, clk_div} = tbl[i];
      wait_on(0);
      tick(1);
      wait_on(0);
      tick(1);
      wait_on(0);
      chk("pace", 16'(n + 1), 16'(pace(tbl[i])));
    end
    auto_mode = 1'b0;
    sequencing_run = 1'b0;
    tick(400);
    $display("pacing test done");
    {oscillator_choice, clk_div} = 5'h0D;
    avg_ratio = 3'h2;
    adc_code = 12'($random(seed));
    starts = 0;
    host_conv_start = 1'b1;
    tick(1);
    host_conv_start = 1'b0;
    wait_on(2);
    chk("average", avg_result, {adc_code, 4'h0});
    chk("samples", 16'(starts), 16'h0004);
    $display("averaging test done");
    conclude();
  end
endmodule
